// ==== fpes_flash_mdl.sv ====
`timescale 1ns/1ps
// ==========================================================================
// flash array model: holds the boundary byte and absorbs byte programming
module fpes_flash_mdl
  import fpes_pkg::*;
(
  // clock
  input  wire logic        clk,
  // program port from the sequencer
  input  wire logic        fl_we,
  input  wire logic [15:0] fl_addr,
  input  wire logic [7:0]  fl_wdata,
  // bench load of a factory value
  input  wire logic        bnd_ld,
  input  wire logic [7:0]  bnd_ld_val,
  // boundary byte as stored in the array
  output logic      [7:0]  bnd_byte
);
  // no reset input: the byte keeps its value across system reset
  logic [7:0] bnd_r = FPES_BND_NONE;

  // bench load, else programming, which only clears bits of the byte
  always_ff @(posedge clk) begin
    if (bnd_ld) begin
      bnd_r <= bnd_ld_val;
    end else if (fl_we && fl_addr == FPES_BND_ADDR) begin
      bnd_r <= bnd_r & fl_wdata;
    end
  end

  assign bnd_byte = bnd_r;
endmodule // fpes_flash_mdl

// ==== fpes_pkg.sv ====
// ==========================================================================
// shared constants and types of the flash program/erase sequencer
package fpes_pkg;

  // ========================================================================
  // register offsets (byte addresses on the bus)
  localparam logic [4:0] FPES_CTRL_OFS  = 5'h00; // flash_control_reg
  localparam logic [4:0] FPES_BND_OFS   = 5'h04; // protect_boundary_reg
  localparam logic [4:0] FPES_ADDR_OFS  = 5'h08; // target flash address
  localparam logic [4:0] FPES_DATA_OFS  = 5'h0c; // flash write port
  localparam logic [4:0] FPES_STAT_OFS  = 5'h10; // sequencer status

  // ========================================================================
  // field positions of flash_control_reg
  localparam int FPES_PGM_BIT   = 0;
  localparam int FPES_ERASE_BIT = 1;
  localparam int FPES_MASS_BIT  = 2;
  localparam int FPES_HV_BIT    = 3;

  // ========================================================================
  // field positions of the status register
  localparam int FPES_ST_PROT_BIT  = 3;
  localparam int FPES_ST_READY_BIT = 4;
  localparam int FPES_ST_STBY_BIT  = 5;
  localparam int FPES_ST_ADDR_LSB  = 16;

  // ========================================================================
  // memory map of the flash array
  localparam logic [15:0] FPES_BND_ADDR   = 16'hff7e; // where the boundary byte lives
  localparam logic [7:0]  FPES_BND_NONE   = 8'hff;    // nothing protected
  localparam int          FPES_ROW_LSB    = 6;        // 64-byte rows
  localparam int          FPES_PAGE_LSB   = 7;        // 128-byte pages

  // ========================================================================
  // reset values
  localparam logic [15:0] FPES_ADDR_RST = 16'h8000;

  // ========================================================================
  // timing: read recovery after high voltage is removed
  localparam int FPES_CLK_MHZ     = 125;
  localparam int FPES_RCV_NS      = 1000; // read_recovery_time, 1 us
  localparam int FPES_RCV_CYC     = (FPES_RCV_NS * FPES_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] FPES_RCV_CNT = 8'(FPES_RCV_CYC);

  // ========================================================================
  // control bits of flash_control_reg
  typedef struct packed {
    logic hv;    // high_voltage_enable
    logic mass;  // whole_array_select
    logic erase; // erase select
    logic program_select;   // program_select
  } fpes_ctrl_t;

  // sequence progress
  typedef enum logic [2:0] {
    FPES_IDLE  = 3'b000,
    FPES_SEL   = 3'b001, // select bit set
    FPES_BRD   = 3'b010, // boundary read done
    FPES_ARMED = 3'b011, // arming write done
    FPES_HV    = 3'b100, // high voltage applied
    FPES_HOLD  = 3'b101  // select cleared, high voltage still on
  } fpes_state_t;

  // one write to the flash array
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpes_flwr_t;

endpackage

// ==== fpes_seq.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Overview of operation
// RQ1: page erase: erase, boundary read, page write
// RQ2: page erase waits before and during high voltage
// RQ3: wait after erase clear, then drop voltage
// RQ4: array erase: erase+whole, boundary read, write
// RQ5: array erase needs longer voltage and hold
// RQ6: monitor failure: arm by writing boundary register
// RQ7: program latches address/data within aligned 64-byte row
// RQ8: program: select, boundary read, row write, voltage
// RQ9: write each byte, wait per byte
// RQ10: never exceed maximum programming time
// RQ11: end programming: clear select, then voltage
// RQ12: erase row before programming it
// RQ13: steps ordered; unrelated accesses do not abort
// RQ14: flash code runs outside flash array
// RQ15: protected target refuses high voltage
// RQ16: boundary read between select and voltage
// RQ17: protect start = 1, bits[14:7], zeros
// RQ18: 00 protects all, FF protects none
// RQ19: boundary byte locked unless test voltage present; code locks it only while the byte is not FF
// RQ20: boundary byte lives in flash, survives reset
// RQ21: wait/stop aborts operation into standby
// RQ22: standby drives all flash controls inactive
// RQ23: erase and program select never both one
// RQ24: voltage only with a select and sequence
// RQ25: track steps, ignore early voltage requests
module fpes_seq
  import fpes_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // classic wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [4:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  // system side
  input  wire logic        low_power_req,
  input  wire logic        monitor_sec_fail,
  input  wire logic        test_high_voltage,
  // flash array side
  input  wire logic [7:0]  bnd_byte,
  output logic             fl_pgm,
  output logic             fl_erase,
  output logic             fl_mass,
  output logic             fl_hv,
  output logic             fl_we,
  output logic      [15:0] fl_addr,
  output logic      [7:0]  fl_wdata,
  output logic             fl_read_ready
);

  // ========================================================================
  // helpers
  // protect start address from the boundary byte
  function automatic logic [15:0] prot_start(input logic [7:0] b);
    prot_start = {1'b1, b, 7'h00}; // RQ17
  endfunction

  // the boundary byte itself stays locked with the range, so a locked
  // part cannot open itself up by erasing or programming its own byte
  // target protected for program or erase
  function automatic logic is_prot(input logic [7:0] b, input logic [15:0] a,
                                   input logic whole, input logic tst);
    logic lock;
    lock    = (b != FPES_BND_NONE) && !tst; // RQ18 RQ19
    is_prot = lock && (whole || a >= prot_start(b) || a == FPES_BND_ADDR); // RQ15
  endfunction

  // ========================================================================
  // state
  fpes_ctrl_t  ctrl_r, ctrl_nxt;
  fpes_state_t st_r, st_nxt;
  fpes_flwr_t  wr_r, wr_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic        prot_r, prot_nxt;
  logic        stby_r, stby_nxt;
  logic [7:0]  rcv_r, rcv_nxt;
  logic        ready_r, ready_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;

  // bus decode
  logic        req, wr, rd;
  logic        wr_ctrl, wr_bnd, wr_addr, wr_data, rd_bnd;
  fpes_ctrl_t  req_c;
  logic        flash_tgt, row_hit;

  // only a data write with address bit 15 set, or a boundary register write during erase after a monitor failure, counts as an arming write, so ram
  // or register traffic between the steps never disturbs the sequence
  assign req       = wb_cyc && wb_stb && !ack_r;
  assign wr        = req && wb_we;
  assign rd        = req && !wb_we;
  assign wr_ctrl   = wr && wb_adr == FPES_CTRL_OFS && wb_sel[0];
  assign wr_bnd    = wr && wb_adr == FPES_BND_OFS && wb_sel[0];
  assign wr_addr   = wr && wb_adr == FPES_ADDR_OFS;
  assign wr_data   = wr && wb_adr == FPES_DATA_OFS && wb_sel[0];
  assign rd_bnd    = rd && wb_adr == FPES_BND_OFS;
  assign req_c     = fpes_ctrl_t'(wb_dat_w[3:0]);
  assign flash_tgt = addr_r[15];
  assign row_hit   = addr_r[15:FPES_ROW_LSB] == tgt_r[15:FPES_ROW_LSB]; // RQ7

  // ========================================================================
  // bus answer: ack one cycle after request, read data with it
  // ack_r masks the request in the ack cycle, so a master that keeps
  // cyc and stb up is taken only every second cycle
  always_comb begin
    ack_nxt  = req;
    rdat_nxt = 32'h0000_0000;
    if (rd) begin
      case (wb_adr)
        FPES_CTRL_OFS: rdat_nxt = {28'h0000000, ctrl_r};
        FPES_BND_OFS:  rdat_nxt = {24'h000000, bnd_byte}; // RQ20
        FPES_ADDR_OFS: rdat_nxt = {16'h0000, addr_r};
        FPES_STAT_OFS: rdat_nxt = {tgt_r, 10'h000, stby_r, ready_r, prot_r, st_r};
        default:       rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // sequence tracking and control bits
  always_comb begin
    ctrl_nxt   = ctrl_r;
    st_nxt     = st_r;
    tgt_nxt    = tgt_r;
    prot_nxt   = prot_r;
    addr_nxt   = addr_r;
    stby_nxt   = stby_r;
    wr_nxt     = wr_r;
    wr_nxt.we  = 1'b0;
    if (wr_addr) begin
      if (wb_sel[0]) addr_nxt[7:0]  = wb_dat_w[7:0];
      if (wb_sel[1]) addr_nxt[15:8] = wb_dat_w[15:8];
    end
    if (low_power_req) begin
      // wait/stop aborts any operation and parks the array
      ctrl_nxt = '0; // RQ21 RQ22
      st_nxt   = FPES_IDLE; // RQ21
      // standby stays marked until the next control write
      stby_nxt = stby_r || ctrl_r != '0; // RQ21
    end else begin
      if (wr_ctrl) begin
        stby_nxt       = 1'b0;
        ctrl_nxt.mass  = req_c.mass;
        // select bits: never both one, never set together
        if (req_c.program_select && req_c.erase && !ctrl_r.program_select && !ctrl_r.erase) begin
          ctrl_nxt.program_select   = 1'b0; // RQ23
          ctrl_nxt.erase = 1'b0; // RQ23
        end else begin
          ctrl_nxt.program_select   = req_c.program_select && !ctrl_r.erase; // RQ23
          ctrl_nxt.erase = req_c.erase && !ctrl_r.program_select; // RQ23
          if (ctrl_r.program_select && req_c.program_select) ctrl_nxt.erase = 1'b0; // RQ23
        end
        // voltage only once select, boundary read and arming are done
        if (req_c.hv && !ctrl_r.hv) begin
          ctrl_nxt.hv = st_r == FPES_ARMED && !prot_r && (ctrl_nxt.program_select || ctrl_nxt.erase); // RQ24 RQ25 RQ15
        end else begin
          ctrl_nxt.hv = req_c.hv && ctrl_r.hv;
        end
        // step tracking
        case (st_r)
          FPES_IDLE: begin
            if (ctrl_nxt.program_select || ctrl_nxt.erase) st_nxt = FPES_SEL;
          end
          FPES_SEL, FPES_BRD, FPES_ARMED: begin
            if (!ctrl_nxt.program_select && !ctrl_nxt.erase) st_nxt = FPES_IDLE;
            else if (ctrl_nxt.hv) st_nxt = FPES_HV;
          end
          FPES_HV: begin
            if (!ctrl_nxt.hv) st_nxt = (ctrl_nxt.program_select || ctrl_nxt.erase) ? FPES_SEL : FPES_IDLE;
            else if (!ctrl_nxt.program_select && !ctrl_nxt.erase) st_nxt = FPES_HOLD; // RQ3 RQ11
          end
          FPES_HOLD: begin
            if (!ctrl_nxt.hv) st_nxt = (ctrl_nxt.program_select || ctrl_nxt.erase) ? FPES_SEL : FPES_IDLE;
          end
          default: st_nxt = FPES_IDLE;
        endcase
      end else if (rd_bnd && st_r == FPES_SEL) begin
        st_nxt = FPES_BRD; // RQ16
      end else if (st_r == FPES_BRD && wr_bnd && monitor_sec_fail && ctrl_r.erase) begin
        // after a failed security check the boundary register is the target
        tgt_nxt  = FPES_BND_ADDR; // RQ6
        prot_nxt = is_prot(bnd_byte, FPES_BND_ADDR, ctrl_r.mass, test_high_voltage); // RQ6 RQ19
        st_nxt   = FPES_ARMED; // RQ6
      end else if (st_r == FPES_BRD && wr_data && flash_tgt) begin
        // arming write latches the page, row or array target
        tgt_nxt  = addr_r; // RQ1 RQ4 RQ7
        prot_nxt = is_prot(bnd_byte, addr_r, ctrl_r.erase && ctrl_r.mass, test_high_voltage); // RQ15
        st_nxt   = FPES_ARMED; // RQ13
      end else if (st_r == FPES_HV && ctrl_r.program_select && wr_data && row_hit) begin
        // data write into the armed row goes to the array
        wr_nxt.we   = 1'b1; // RQ7
        wr_nxt.addr = addr_r; // RQ7
        wr_nxt.data = wb_dat_w[7:0]; // RQ7
      end
    end
  end

  // ========================================================================
  // read recovery after high voltage falls
  // any select or voltage reloads the count; ready rises once it runs
  // out, so the array is never reported readable under voltage
  always_comb begin
    rcv_nxt   = rcv_r;
    ready_nxt = ready_r;
    if (ctrl_nxt.hv || ctrl_nxt.program_select || ctrl_nxt.erase) begin
      rcv_nxt   = FPES_RCV_CNT;
      ready_nxt = 1'b0;
    end else if (rcv_r != 8'h00) begin
      rcv_nxt   = rcv_r - 8'h01;
      ready_nxt = rcv_r == 8'h01;
    end
  end

  // ========================================================================
  // registers
  // no flop here holds the boundary byte: it lives in the array
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r  <= '0;
      st_r    <= FPES_IDLE;
      wr_r    <= '0;
      addr_r  <= FPES_ADDR_RST;
      tgt_r   <= FPES_ADDR_RST;
      prot_r  <= 1'b0;
      stby_r  <= 1'b0;
      rcv_r   <= 8'h00;
      ready_r <= 1'b1;
      ack_r   <= 1'b0;
      rdat_r  <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      st_r    <= st_nxt;
      wr_r    <= wr_nxt;
      addr_r  <= addr_nxt;
      tgt_r   <= tgt_nxt;
      prot_r  <= prot_nxt;
      stby_r  <= stby_nxt;
      rcv_r   <= rcv_nxt;
      ready_r <= ready_nxt;
      ack_r   <= ack_nxt;
      rdat_r  <= rdat_nxt;
    end
  end

  // outputs straight from flops
  assign wb_ack        = ack_r;
  assign wb_dat_r      = rdat_r;
  assign fl_pgm        = ctrl_r.program_select;
  assign fl_erase      = ctrl_r.erase;
  assign fl_mass       = ctrl_r.mass;
  assign fl_hv         = ctrl_r.hv;
  assign fl_we         = wr_r.we;
  assign fl_addr       = wr_r.addr;
  assign fl_wdata      = wr_r.data;
  assign fl_read_ready = ready_r;

  // ========================================================================
  // checks
  sel_interlock_a: assert property (@(posedge clk) disable iff (rst) // RQ23
    !(fl_pgm && fl_erase)) else $error("program and erase selected together");

  hv_needs_arm_a: assert property (@(posedge clk) disable iff (rst) // RQ25
    $rose(fl_hv) |-> $past(st_r) == FPES_ARMED) else $error("voltage before sequence done");

  hv_needs_sel_a: assert property (@(posedge clk) disable iff (rst) // RQ24
    $rose(fl_hv) |-> (fl_pgm || fl_erase)) else $error("voltage without select");

  prot_block_a: assert property (@(posedge clk) disable iff (rst) // RQ15
    $rose(fl_hv) |-> !prot_r) else $error("voltage on protected target");

  all_prot_a: assert property (@(posedge clk) disable iff (rst) // RQ18
    (st_r == FPES_ARMED && bnd_byte == 8'h00 && !test_high_voltage && $stable(bnd_byte)
     && $past(st_r) == FPES_BRD) |-> prot_r) else $error("zero boundary left target open");

  standby_a: assert property (@(posedge clk) disable iff (rst) // RQ21
    low_power_req |=> (!fl_hv && !fl_pgm && !fl_erase && !fl_mass && st_r == FPES_IDLE))
    else $error("low power did not park the array");

  row_write_a: assert property (@(posedge clk) disable iff (rst) // RQ7
    fl_we |-> (fl_pgm && fl_hv && fl_addr[15:6] == tgt_r[15:6])) else $error("write outside armed row");

  bus_ack_a: assert property (@(posedge clk) disable iff (rst)
    (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack) else $error("ack not one cycle");

  recover_a: assert property (@(posedge clk) disable iff (rst) // RQ3 RQ11
    $fell(fl_hv) && !fl_pgm && !fl_erase && !low_power_req |-> !fl_read_ready [*8])
    else $error("read ready too early after voltage");

  // ========================================================================
  // sequence and protection checks
  stby_mark_a: assert property (@(posedge clk) disable iff (rst) // RQ21
    (low_power_req && (fl_pgm || fl_erase || fl_hv)) |=> stby_r)
    else $error("aborted operation not marked standby");

  set_alone_a: assert property (@(posedge clk) disable iff (rst) // RQ23
    $rose(fl_pgm) |-> !$past(fl_erase))
    else $error("program selected while erase was on");

  we_pulse_a: assert property (@(posedge clk) disable iff (rst) // RQ7
    fl_we |=> !fl_we)
    else $error("program strobe longer than one cycle");

  we_unprot_a: assert property (@(posedge clk) disable iff (rst) // RQ15
    fl_we |-> !prot_r)
    else $error("byte programmed into protected row");

  rd_idle_zero_a: assert property (@(posedge clk) disable iff (rst)
    !wb_ack |-> wb_dat_r == 32'h0000_0000)
    else $error("read data outside acknowledge");

  hv_not_ready_a: assert property (@(posedge clk) disable iff (rst) // RQ3
    fl_hv |-> !fl_read_ready)
    else $error("array readable under high voltage");

  idle_no_hv_a: assert property (@(posedge clk) disable iff (rst) // RQ24
    st_r == FPES_IDLE |-> !fl_hv)
    else $error("voltage on with no operation");

  brd_by_read_a: assert property (@(posedge clk) disable iff (rst) // RQ16
    (st_r == FPES_BRD && $past(st_r) == FPES_SEL) |-> $past(rd_bnd))
    else $error("boundary step without boundary read");

  free_all_a: assert property (@(posedge clk) disable iff (rst) // RQ18
    (st_r == FPES_ARMED && $past(st_r) == FPES_BRD && $past(bnd_byte) == FPES_BND_NONE) |-> !prot_r)
    else $error("erased boundary byte protected a target");

  tst_lifts_a: assert property (@(posedge clk) disable iff (rst) // RQ19
    (st_r == FPES_ARMED && $past(st_r) == FPES_BRD && $past(test_high_voltage)) |-> !prot_r)
    else $error("test voltage did not lift protection");

  mon_target_a: assert property (@(posedge clk) disable iff (rst) // RQ6
    (st_r == FPES_ARMED && $past(st_r) == FPES_BRD && $past(wr_bnd)) |-> tgt_r == FPES_BND_ADDR)
    else $error("monitor arming missed the boundary register");

endmodule // fpes_seq

// ==== tb_flash_program_erase_sequencer.sv ====
`timescale 1ns/1ps
// ==========================================================================
// bench: wishbone driver, expectation queues and a watching process
module tb_flash_program_erase_sequencer;
  import fpes_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [4:0]  wb_adr = 5'h00;
  logic [3:0]  wb_sel = 4'hf;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic        wb_ack, low_power_req = 1'b0, monitor_sec_fail = 1'b0, test_high_voltage = 1'b0;
  logic [7:0]  bnd_byte, fl_wdata;
  logic        fl_pgm, fl_erase, fl_mass, fl_hv, fl_we, fl_read_ready;
  logic [15:0] fl_addr;
  logic [31:0] rq_v[$], rq_m[$], ev, em;
  logic [23:0] fq[$];
  int          errors = 0, n_compared = 0;
  logic        bnd_ld = 1'b0;
  logic [7:0]  bnd_ld_val = 8'hff;
  // software waits in cycles; erase times are cut short, the sequencer does not time them
  localparam int SETUP_CYC = 1250; // setup_before_high_voltage, 10 us
  localparam int PGS_CYC   = 625;  // program_setup_time, 5 us
  localparam int HOLD_CYC  = 625;  // hold_after_select_clear, 5 us
  localparam int PROG_CYC  = 3750; // byte_program_time, 30 us

  // ========================================================================
  // clock, design and array model
  always #4 clk = ~clk;
  fpes_seq i_fpes_seq (.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .low_power_req(low_power_req),
    .monitor_sec_fail(monitor_sec_fail), .test_high_voltage(test_high_voltage), .bnd_byte(bnd_byte),
    .fl_pgm(fl_pgm), .fl_erase(fl_erase), .fl_mass(fl_mass), .fl_hv(fl_hv), .fl_we(fl_we), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_read_ready(fl_read_ready));
  fpes_flash_mdl i_fpes_flash_mdl (.clk(clk), .fl_we(fl_we), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .bnd_ld(bnd_ld), .bnd_ld_val(bnd_ld_val), .bnd_byte(bnd_byte));

  // ========================================================================
  // comparison and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ========================================================================
  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [4:0] adr, input logic [31:0] d);
    int i;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_w <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      print_verdict();
    end else begin
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
    end
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask

  // load a value into the stored boundary byte of the array model
  task automatic set_bnd(input logic [7:0] v);
    bnd_ld     <= 1'b1;
    bnd_ld_val <= v;
    @(posedge clk);
    bnd_ld     <= 1'b0;
  endtask

  // note the masked expectation, then read
  task automatic rd(input logic [4:0] adr, input logic [31:0] v, input logic [31:0] m);
    rq_v.push_back(v);
    rq_m.push_back(m);
    bus(1'b0, adr, 32'h0);
  endtask

  // select, boundary read, arming write, then ask for high voltage
  task automatic arm(input logic [3:0] sel, input logic [15:0] a, input logic exp_hv);
    wr(FPES_CTRL_OFS, {28'h0, sel});
    rd(FPES_BND_OFS, {24'h0, bnd_byte}, 32'hff);
    wr(FPES_ADDR_OFS, {16'h0, a});
    wr(FPES_DATA_OFS, 32'($urandom) & 32'hff);
    repeat (SETUP_CYC) @(posedge clk);
    wr(FPES_CTRL_OFS, {28'h0, sel | 4'h8});
    chk(32'(fl_hv), 32'(exp_hv));
    chk(32'(fl_mass), 32'(sel[2]));
    repeat (PGS_CYC) @(posedge clk);
  endtask

  // clear select, then voltage, then time the read recovery
  task automatic fin(input logic hv_on);
    int n;
    wr(FPES_CTRL_OFS, 32'h8);
    chk(32'(fl_hv), 32'(hv_on));
    repeat (HOLD_CYC) @(posedge clk);
    wr(FPES_CTRL_OFS, 32'h0);
    for (n = 0; n < 400 && fl_read_ready !== 1'b1; n++) @(posedge clk);
    chk(32'(n <= 126 && (!hv_on || n >= 120)), 32'h1);
    if (n == 400) print_verdict();
  endtask

  // ========================================================================
  // watcher: each result takes the oldest note of its queue
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      ev = (rq_v.size() > 0) ? rq_v.pop_front() : 32'hdead_beef;
      em = (rq_m.size() > 0) ? rq_m.pop_front() : 32'hffff_ffff;
      chk(wb_dat_r & em, ev & em);
    end
    if (fl_we === 1'b1) chk({8'h0, fl_addr, fl_wdata}, {8'h0, (fq.size() > 0) ? fq.pop_front() : 24'hx});
  end

  // ========================================================================
  // main sequence
  logic [7:0] pb[8] = '{8'hff, 8'h01, 8'h01, 8'h00, 8'hfe, 8'hfe, 8'hff, 8'h01};
  logic [15:0] pa[8] = '{16'h8000, 16'h8000, 16'h8080, 16'h8000, 16'hff00, 16'hfe80, 16'h8000, 16'h8000};
  logic [7:0] d;
  initial begin
    void'($urandom(32'h139a));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(FPES_STAT_OFS, 32'h10, 32'h3f);
    rd(FPES_ADDR_OFS, {16'h0, FPES_ADDR_RST}, 32'hffff);
    rd(5'h14, 32'h0, 32'hffff_ffff);
    // early voltage request without boundary read is ignored
    wr(FPES_CTRL_OFS, 32'h2);
    wr(FPES_CTRL_OFS, 32'ha);
    chk(32'(fl_hv), 32'h0);
    fin(1'b0);
    // interlock: both from zero sets neither, second keeps the first
    wr(FPES_CTRL_OFS, 32'h3);
    chk(32'({fl_pgm, fl_erase}), 32'h0);
    wr(FPES_CTRL_OFS, 32'h1);
    wr(FPES_CTRL_OFS, 32'h3);
    chk(32'({fl_pgm, fl_erase}), 32'h2);
    fin(1'b0);
    // protection table over page and whole-array erase
    for (int k = 0; k < 8; k++) begin
      set_bnd(pb[k]);
      arm(k >= 6 ? 4'h6 : 4'h2, pa[k], k == 0 || k == 1 || k == 5 || k == 6);
      fin(k == 0 || k == 1 || k == 5 || k == 6);
    end
    // test voltage lifts full protection
    test_high_voltage <= 1'b1;
    set_bnd(8'h00);
    arm(4'h2, 16'h8000, 1'b1);
    fin(1'b1);
    test_high_voltage <= 1'b0;
    set_bnd(8'hff);
    // erase the page first, then program: bytes in the row latch, outside is ignored
    arm(4'h2, 16'h9000, 1'b1);
    fin(1'b1);
    arm(4'h1, 16'h9040, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      fq.push_back({16'h9040 + 16'(k * 21), d});
      wr(FPES_ADDR_OFS, 32'h9040 + k * 21);
      wr(FPES_DATA_OFS, {24'h0, d});
      repeat (PROG_CYC) @(posedge clk);
    end
    wr(FPES_ADDR_OFS, 32'h9080);
    wr(FPES_DATA_OFS, 32'h55);
    fin(1'b1);
    chk(32'(fq.size()), 32'h0);
    // monitor arming through the boundary register
    monitor_sec_fail <= 1'b1;
    wr(FPES_CTRL_OFS, 32'h2);
    rd(FPES_BND_OFS, 32'hff, 32'hff);
    wr(FPES_BND_OFS, 32'h0);
    rd(FPES_STAT_OFS, {FPES_BND_ADDR, 16'h3}, 32'hffff_0007);
    wr(FPES_CTRL_OFS, 32'ha);
    chk(32'(fl_hv), 32'h1);
    fin(1'b1);
    monitor_sec_fail <= 1'b0;
    // low power during an operation drops every control
    arm(4'h1, 16'h8000, 1'b1);
    low_power_req <= 1'b1;
    repeat (2) @(posedge clk);
    low_power_req <= 1'b0;
    chk(32'({fl_pgm, fl_erase, fl_mass, fl_hv}), 32'h0);
    rd(FPES_STAT_OFS, 32'h20, 32'h27);
    // boundary byte survives a reset in mid-run
    set_bnd(8'h5a);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(FPES_BND_OFS, 32'h5a, 32'hff);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // tb_flash_program_erase_sequencer
